// ### design/asf_pkg.sv
package asf_pkg;

    // ============================================================
    // Instruction field positions (bit 0 is the MSB, word bit 15)
    localparam int ROT_SEL_HI     = 7;
    localparam int ROT_SEL_LO     = 6;
    localparam int CARRY_BASE_HI  = 5;
    localparam int CARRY_BASE_LO  = 4;
    localparam int STORE_INH_BIT  = 3;
    localparam int BRANCH_HI      = 2;
    localparam int BRANCH_LO      = 0;
    localparam int OPCODE_HI      = 10;
    localparam int OPCODE_LO      = 8;

    // ============================================================
    // Field encodings
    typedef enum logic [1:0]
    {
        ASF_ROT_NONE  = 2'h0,
        ASF_ROT_LEFT  = 2'h1,
        ASF_ROT_RIGHT = 2'h2,
        ASF_ROT_SWAP  = 2'h3
    } asf_rot_t;

    typedef enum logic [1:0]
    {
        ASF_CB_KEEP = 2'h0,
        ASF_CB_ZERO = 2'h1,
        ASF_CB_ONE  = 2'h2,
        ASF_CB_INV  = 2'h3
    } asf_cbase_t;

    typedef enum logic [2:0]
    {
        ASF_BO_NEVER       = 3'h0,
        ASF_BO_ALWAYS      = 3'h1,
        ASF_BO_CARRY_CLEAR = 3'h2,
        ASF_BO_CARRY_SET   = 3'h3,
        ASF_BO_RES_ZERO    = 3'h4,
        ASF_BO_RES_NONZERO = 3'h5,
        ASF_BO_EITHER_ZERO = 3'h6,
        ASF_BO_BOTH_NZ     = 3'h7
    } asf_skip_t;

    typedef enum logic [2:0]
    {
        ASF_OP_INVERT   = 3'h0,
        ASF_OP_NEGATE   = 3'h1,
        ASF_OP_PASS     = 3'h2,
        ASF_OP_INC      = 3'h3,
        ASF_OP_ADDCOMP  = 3'h4,
        ASF_OP_SUB      = 3'h5,
        ASF_OP_ADD      = 3'h6,
        ASF_OP_AND      = 3'h7
    } asf_op_t;

    // ============================================================
    // Reset values and program counter increments
    localparam logic [15:0] ACC_RESET   = 16'h0000;
    localparam logic        CARRY_RESET = 1'h0;
    localparam logic [14:0] PC_RESET    = 15'h0000;
    localparam logic [14:0] PC_STEP     = 15'h0001;
    localparam logic [14:0] PC_SKIP     = 15'h0002;

    typedef struct packed
    {
        logic [15:0] acc;
        logic        carry;
        logic [14:0] pc;
        logic        wr_en;
        logic        skip;
    } asf_state_t;

endpackage : asf_pkg

// ### design/asf_unit.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// RULE_01: Code 00 passes result and carry unchanged
// RULE_02: Code 01 rotates 17 bits left
// RULE_03: Code 10 rotates 17 bits right
// RULE_04: Code 11 swaps bytes, carry unchanged
// RULE_05: Carry base 00 current, 01 zero
// RULE_06: Carry base 10 one, 11 inverted
// RULE_07: Logical ops pass base carry unmodified
// RULE_08: Arithmetic ops invert base on carry-out
// RULE_09: Store inhibit clear writes accumulator and carry
// RULE_10: Skip field selects test on shifter output
// RULE_11: Code 000 never, 001 always skip
// RULE_12: Codes 010/011 test new carry
// RULE_13: Codes 100/101 test result zero
// RULE_14: Codes 110/111 combine carry and result
// RULE_15: Carry and result form 17-bit operand
// RULE_16: Skip evaluated even when store inhibited
// RULE_17: Taken skip advances program counter by two
module asf_unit
    import asf_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        instr_valid,
    input  wire logic [15:0] instr_word,
    input  wire logic [15:0] alu_result,
    input  wire logic        alu_carry_out,
    output logic      [15:0] destination_accumulator,
    output logic             carry_flag,
    output logic      [14:0] program_counter,
    output logic             acc_write,
    output logic             skip_taken
);

    asf_state_t st_reg;
    asf_state_t st_next;

    asf_rot_t    rotate_select_field;
    asf_cbase_t  carry_base_field;
    logic        result_store_inhibit;
    asf_skip_t   branch_over_field;
    asf_op_t     opcode;
    logic        base_carry;
    logic        alu_derived_carry;
    logic [16:0] operand;
    logic [15:0] shifted_result;
    logic        shifted_carry_out;
    logic        res_zero;
    logic        branch_over_hit;
    logic [15:0] rot_left_word;
    logic [15:0] rot_right_word;

    assign rotate_select_field  = asf_rot_t'(instr_word[ROT_SEL_HI:ROT_SEL_LO]);
    assign carry_base_field     = asf_cbase_t'(instr_word[CARRY_BASE_HI:CARRY_BASE_LO]);
    assign result_store_inhibit = instr_word[STORE_INH_BIT];
    assign branch_over_field    = asf_skip_t'(instr_word[BRANCH_HI:BRANCH_LO]);
    assign opcode               = asf_op_t'(instr_word[OPCODE_HI:OPCODE_LO]);

    // ============================================================
    // Carry selection
    always_comb
    begin
        case (carry_base_field)
            ASF_CB_KEEP:
            begin
                base_carry = st_reg.carry;     // [RULE_05]
            end
            ASF_CB_ZERO:
            begin
                base_carry = 1'b0;             // [RULE_05]
            end
            ASF_CB_ONE:
            begin
                base_carry = 1'b1;             // [RULE_06]
            end
            default:
            begin
                base_carry = ~st_reg.carry;    // [RULE_06]
            end
        endcase
        // Carry-out flips the base only for arithmetic classes
        case (opcode)
            ASF_OP_INVERT, ASF_OP_PASS, ASF_OP_AND:
            begin
                alu_derived_carry = base_carry;                   // [RULE_07]
            end
            default:
            begin
                alu_derived_carry = base_carry ^ alu_carry_out;   // [RULE_08]
            end
        endcase
    end

    // ============================================================
    // Shifter; vector bit 15 is the instruction-set MSB (bit 0)
    assign operand = {alu_derived_carry, alu_result};   // [RULE_15]

    // ============================================================
    // Per-bit rotate taps; the carry closes the 17-bit ring
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1)
        begin : g_rot_bit
            if (gi == 0)
            begin : g_lsb
                assign rot_left_word[gi]  = operand[16];         // [RULE_02]
                assign rot_right_word[gi] = operand[gi + 1];
            end
            else if (gi == 15)
            begin : g_msb
                assign rot_left_word[gi]  = operand[gi - 1];
                assign rot_right_word[gi] = operand[16];         // [RULE_03]
            end
            else
            begin : g_mid
                assign rot_left_word[gi]  = operand[gi - 1];
                assign rot_right_word[gi] = operand[gi + 1];
            end
        end
    endgenerate

    always_comb
    begin
        case (rotate_select_field)
            ASF_ROT_NONE:
            begin
                shifted_result    = operand[15:0];                 // [RULE_01]
                shifted_carry_out = operand[16];
            end
            ASF_ROT_LEFT:
            begin
                shifted_result    = rot_left_word;                 // [RULE_02]
                shifted_carry_out = operand[15];
            end
            ASF_ROT_RIGHT:
            begin
                shifted_result    = rot_right_word;                // [RULE_03]
                shifted_carry_out = operand[0];
            end
            default:
            begin
                shifted_result    = {operand[7:0], operand[15:8]}; // [RULE_04]
                shifted_carry_out = operand[16];
            end
        endcase
    end

    // ============================================================
    // Skip test, independent of store inhibit
    assign res_zero = (shifted_result == 16'h0000);

    always_comb
    begin
        case (branch_over_field)                                           // [RULE_10] [RULE_16]
            ASF_BO_NEVER:
            begin
                branch_over_hit = 1'b0;                                  // [RULE_11]
            end
            ASF_BO_ALWAYS:
            begin
                branch_over_hit = 1'b1;                                  // [RULE_11]
            end
            ASF_BO_CARRY_CLEAR:
            begin
                branch_over_hit = ~shifted_carry_out;                    // [RULE_12]
            end
            ASF_BO_CARRY_SET:
            begin
                branch_over_hit = shifted_carry_out;                     // [RULE_12]
            end
            ASF_BO_RES_ZERO:
            begin
                branch_over_hit = res_zero;                              // [RULE_13]
            end
            ASF_BO_RES_NONZERO:
            begin
                branch_over_hit = ~res_zero;                             // [RULE_13]
            end
            ASF_BO_EITHER_ZERO:
            begin
                branch_over_hit = ~shifted_carry_out | res_zero;         // [RULE_14]
            end
            default:
            begin
                branch_over_hit = shifted_carry_out & ~res_zero;         // [RULE_14]
            end
        endcase
    end

    // ============================================================
    // State update
    always_comb
    begin
        st_next       = st_reg;
        st_next.wr_en = 1'b0;
        st_next.skip  = 1'b0;
        if (instr_valid)
        begin
            if (!result_store_inhibit)
            begin
                st_next.acc   = shifted_result;      // [RULE_09]
                st_next.carry = shifted_carry_out;   // [RULE_09]
                st_next.wr_en = 1'b1;
            end
            st_next.skip = branch_over_hit;
            st_next.pc   = st_reg.pc + (branch_over_hit ? PC_SKIP : PC_STEP);  // [RULE_17]
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_reg <= '{acc: ACC_RESET, carry: CARRY_RESET, pc: PC_RESET,
                        wr_en: 1'b0, skip: 1'b0};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign destination_accumulator = st_reg.acc;
    assign carry_flag              = st_reg.carry;
    assign program_counter         = st_reg.pc;
    assign acc_write               = st_reg.wr_en;
    assign skip_taken              = st_reg.skip;

endmodule : asf_unit

`default_nettype wire

// ### test/asf_unit_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module asf_unit_monitor
    import asf_pkg::*;
(
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic [15:0] alu_result,
    input wire logic        alu_carry_out,
    input wire logic [15:0] destination_accumulator,
    input wire logic        carry_flag,
    input wire logic [14:0] program_counter,
    input wire logic        acc_write,
    input wire logic        skip_taken
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    logic       ld;
    logic [1:0] rot;
    assign ld  = instr_valid && !instr_word[3];
    assign rot = instr_word[7:6];
    AST_STEP: assert property (instr_valid |=> program_counter ==
        $past(program_counter) + (skip_taken ? 15'h2 : 15'h1)) else $error("pc step");
    AST_IDLE: assert property (!instr_valid |=> !acc_write && !skip_taken)
        else $error("idle pulse");
    AST_LOAD: assert property (instr_valid |=> acc_write == !$past(instr_word[3]))
        else $error("write pulse");
    AST_HOLD: assert property (instr_valid && instr_word[3] |=>
        $stable(destination_accumulator) && $stable(carry_flag)) else $error("inhibit");
    AST_NOSH: assert property (ld && rot == 2'h0 |=> destination_accumulator ==
        $past(alu_result)) else $error("no shift");
    AST_SWAP: assert property (ld && rot == 2'h3 |=> destination_accumulator ==
        {$past(alu_result[7:0]), $past(alu_result[15:8])}) else $error("swap");
    AST_LCY: assert property (ld && rot == 2'h1 |=> carry_flag == $past(alu_result[15]))
        else $error("left carry");
    AST_RCY: assert property (ld && rot == 2'h2 |=> carry_flag == $past(alu_result[0]))
        else $error("right carry");
    AST_FIXED_BRANCH: assert property (instr_valid && instr_word[2:1] == 2'h0 |=>
        skip_taken == $past(instr_word[0])) else $error("skip never/always");
endmodule : asf_unit_monitor
bind asf_unit asf_unit_monitor u_mon (.clk(clk), .rstn(rstn), .instr_valid(instr_valid),
    .instr_word(instr_word), .alu_result(alu_result), .alu_carry_out(alu_carry_out),
    .destination_accumulator(destination_accumulator), .carry_flag(carry_flag),
    .program_counter(program_counter), .acc_write(acc_write), .skip_taken(skip_taken));
`default_nettype wire

// ### test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import asf_pkg::*;
;
    logic        clk = 0, rstn = 0, iv = 0, co = 0, cf, aw, bo, m_c = 0;
    logic [15:0] iw = 0, res = 0, lf = 16'h0056, acc, m_acc = 0;
    logic [14:0] pc, m_pc = 0;
    logic [33:0] q[$];
    int          n_mismatch = 0, comparisons = 0, cyc = 0;
    always #12.5 clk = ~clk;
    asf_unit dut (.clk(clk), .rstn(rstn), .instr_valid(iv), .instr_word(iw), .alu_result(res),
        .alu_carry_out(co), .destination_accumulator(acc), .carry_flag(cf),
        .program_counter(pc), .acc_write(aw), .skip_taken(bo));
    // ==========
    // Model and driver
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr
    task automatic issue(input logic [15:0] w, r, input logic ci);
        logic b, c;
        logic [15:0] y;
        logic [7:0] t;
        b = w[5:4] == 2'h0 ? m_c : w[5:4] == 2'h1 ? 1'b0 : w[5:4] == 2'h2 ? 1'b1 : !m_c;
        if (w[10:8] inside {3'h1, 3'h3, 3'h4, 3'h5, 3'h6})
            b = b ^ ci;
        case (w[7:6])
            2'h0: {c, y} = {b, r};
            2'h1: {c, y} = {r[15], r[14:0], b};
            2'h2: {c, y} = {r[0], b, r[15:1]};
            default: {c, y} = {b, r[7:0], r[15:8]};
        endcase
        t = {c && y != 0, !c || y == 0, y != 0, y == 0, c, !c, 1'b1, 1'b0};
        if (!w[3])
        begin
            m_acc = y;
            m_c = c;
        end
        m_pc = m_pc + (t[w[2:0]] ? 15'h2 : 15'h1);
        q.push_back({m_acc, m_c, m_pc, !w[3], t[w[2:0]]});
        iw = w;
        res = r;
        co = ci;
        iv = 1;
        @(posedge clk);
        #1;
    endtask : issue
    task automatic check(input logic [33:0] e);
        comparisons++;
        if ({acc, cf, pc, aw, bo} !== e)
        begin
            n_mismatch++;
            $display("Error %0t exp %h got %h", $time, e, {acc, cf, pc, aw, bo});
        end
    endtask : check
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    // ==========
    // Result watcher and timeout
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_mismatch++;
            give_verdict();
        end
        else if (rstn && iv)
        begin
            #2;
            check(q.pop_front());
        end
    end
    // ==========
    // Tests
    initial
    begin
        repeat (5) @(posedge clk);
        #1;
        check(34'h0);
        rstn = 1;
        for (int i = 0; i < 1024; i++)
        begin
            lf = lfsr(lf);
            issue({lf[15:11], i[2:0], i[4:3], i[6:5], lf[0], i[9:7]}, i % 7 ? lf : 16'h0, lf[5]);
        end
        iv = 0;
        $display("test all_fields done");
        @(posedge clk);
        #1;
        rstn = 0;
        {m_acc, m_c, m_pc} = 0;
        @(posedge clk);
        #1;
        check(34'h0);
        rstn = 1;
        repeat (200)
        begin
            lf = lfsr(lf);
            if (lf[1])
                issue(lf, lfsr(lf), lf[2]);
            else
            begin
                iv = 0;
                @(posedge clk);
                #1;
            end
        end
        if (iv)
            iv = 0;
        repeat (2) @(posedge clk);
        $display("test random_gaps done");
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
